// [logic/pp_pkg.sv]
// Shared constants and types for the pressure post-processing block
package pp_pkg;

    // Register byte offsets
    localparam logic [7:0] PP_OFS_OUT_MODE = 8'h00;
    localparam logic [7:0] PP_OFS_UNIT = 8'h04;
    localparam logic [7:0] PP_OFS_USER_FACTOR = 8'h08;
    localparam logic [7:0] PP_OFS_TEMP_UNIT = 8'h0C;
    localparam logic [7:0] PP_OFS_TARE_STATE = 8'h10;
    localparam logic [7:0] PP_OFS_TARE_OFFSET = 8'h14;
    localparam logic [7:0] PP_OFS_TARE_LOCK = 8'h18;
    localparam logic [7:0] PP_OFS_EXT_CLEAR = 8'h1C;
    localparam logic [7:0] PP_OFS_LOW_VALUE = 8'h20;
    localparam logic [7:0] PP_OFS_LOW_STAMP = 8'h24;
    localparam logic [7:0] PP_OFS_HIGH_VALUE = 8'h28;
    localparam logic [7:0] PP_OFS_HIGH_STAMP = 8'h2C;
    localparam logic [7:0] PP_OFS_FORMAT = 8'h30;
    localparam logic [7:0] PP_OFS_PRESSURE = 8'h34;
    localparam logic [7:0] PP_OFS_TEMP = 8'h38;
    localparam logic [7:0] PP_OFS_STATUS = 8'h3C;

    // Format register fields
    localparam int PP_FMT_DATE_LSB = 0;
    localparam int PP_FMT_TIME_LSB = 4;
    localparam int PP_FMT_PORT_BIT = 8;

    // Mode codes that select a mask stream, the highest combination mode code and the highest unit code
    localparam logic [3:0] PP_MODE_MASK1 = 4'h8;
    localparam logic [3:0] PP_MODE_MASK2 = 4'hA;
    localparam logic [3:0] PP_MODE_MASK3 = 4'hC;
    localparam logic [3:0] PP_MODE_MAX_COMBO = 4'h7;
    localparam logic [3:0] PP_UNIT_MAX = 4'h8;

    // Unit factors, signed Q16.16
    localparam logic signed [31:0] PP_F_PSI = 32'h0001_0000;
    localparam logic signed [31:0] PP_F_HPA = 32'h0044_F294;
    localparam logic signed [31:0] PP_F_BAR = 32'h0000_11A7;
    localparam logic signed [31:0] PP_F_KPA = 32'h0006_E50F;
    localparam logic signed [31:0] PP_F_MPA = 32'h0000_01C4;
    localparam logic signed [31:0] PP_F_INHG = 32'h0002_0939;
    localparam logic signed [31:0] PP_F_MMHG = 32'h0033_B706;
    localparam logic signed [31:0] PP_F_MH2O = 32'h0000_B3FC;
    localparam logic signed [31:0] PP_USER_FACTOR_RST = 32'h0001_0000;

    // Celsius to Fahrenheit, Q16.16
    localparam logic signed [31:0] PP_F_NINE_FIFTHS = 32'h0001_CCCD;
    localparam logic signed [31:0] PP_F_OFFSET32 = 32'h0020_0000;

    localparam logic signed [31:0] PP_TARE_OFFSET_RST = 32'h0000_0000;
    localparam logic [3:0] PP_MODE_RST = 4'h0;
    localparam logic [3:0] PP_UNIT_RST = 4'h1;

    typedef enum logic [1:0] {
        PP_TARE_OFF,
        PP_TARE_PEND,
        PP_TARE_ON
    } pp_tare_t;

    typedef enum logic [1:0] {
        PP_SEL_PRESSURE,
        PP_SEL_MASK1,
        PP_SEL_MASK2,
        PP_SEL_MASK3
    } pp_stream_sel_t;

    typedef struct packed {
        logic display;
        logic stream;
        logic fan_mark;
        pp_stream_sel_t sel;
    } pp_mode_t;

    typedef struct packed {
        logic signed [31:0] value;
        logic [31:0] stamp;
    } pp_extreme_t;

endpackage

// [logic/pp_postproc_top.sv]
// Pressure scaling, tare, extreme tracking and output mode control
`timescale 1ns/1ps

// Notes on behaviour
// - Extremes read in current unit with stamps
// - Clear command reloads both extremes, then acknowledges
// - Reload extremes after power-up, tare, coefficients
// - Output mode kept nonvolatile across power cycles
// - Decode modes 0-7 and mask modes 8,10,12
// - Display output on selected port
// - Stream selected data type on selected port
// - Plus marker on air temperature when fan fails
// - Single measurement pauses stream until done
// - Continuous measurement holds off pressure stream
// - Unit codes 0 to 8, zero user unit
// - Psi value multiplied by unit factor
// - User unit uses user factor, default one
// - Celsius native, Fahrenheit when selection is one
// - Tare off at power-up, request when unlocked
// - Capture offset at next measurement, then subtract
// - Repeat request recaptures new offset
// - Writing zero switches tare off
// - Offset writable while tare on, zero at reset
// - Lockout blocks tare state changes
// - Pending capture completes despite lockout
module pp_postproc_top
    import pp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MEAS_VALID,
    input wire logic signed [31:0] MEAS_PSI,
    input wire logic [31:0] TIME_STAMP,
    input wire logic signed [31:0] SENSOR_TEMP_C,
    input wire logic COEFF_CHANGED,
    input wire logic TARE_REQ_IN,
    input wire logic SINGLE_MEAS_BUSY,
    input wire logic CONT_MEAS_ACTIVE,
    input wire logic FAN_FAULT,
    input wire logic [3:0] NV_MODE_IN,
    output logic NV_SAVE_STB,
    output logic [3:0] NV_SAVE_DATA,
    output logic signed [31:0] PRESSURE_OUT,
    output logic PRESSURE_VALID,
    output logic signed [31:0] TEMP_OUT,
    output logic CLEAR_ACK,
    output logic DISPLAY_EN,
    output logic STREAM_EN,
    output logic [1:0] STREAM_SEL,
    output logic OUT_PORT_SEL,
    output logic AIR_TEMP_PLUS,
    output logic [3:0] DATE_FMT,
    output logic [3:0] TIME_FMT
);

    logic [3:0] mode_code_ff;
    logic nv_loaded_ff;
    logic [3:0] unit_ff;
    logic signed [31:0] user_factor_ff;
    logic temp_unit_ff;
    pp_tare_t tare_ff;
    pp_tare_t nxt_tare;
    logic signed [31:0] tare_offset_ff;
    logic lock_ff;
    logic reload_ff;
    logic ack_pend_ff;
    pp_extreme_t low_ff;
    pp_extreme_t high_ff;
    logic [8:0] format_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic signed [31:0] pressure_ff;
    logic pvalid_ff;
    logic signed [31:0] temp_ff;
    logic ack_ff;
    logic nv_stb_ff;
    logic [3:0] nv_data_ff;

    logic setup_ph;
    logic wr_en;
    logic signed [31:0] tared;
    logic capture;
    logic tare_set_req;
    logic tare_wr;
    logic reload_set;
    logic signed [31:0] factor;
    pp_mode_t mode;
    logic [31:0] rdata;
    logic rdata_err;

    // Unit factor lookup; zero picks the software factor
    function automatic logic signed [31:0] unit_factor(
        input logic [3:0] u,
        input logic signed [31:0] user
    );
        case (u)
            4'h1: unit_factor = PP_F_PSI;
            4'h2: unit_factor = PP_F_HPA;
            4'h3: unit_factor = PP_F_BAR;
            4'h4: unit_factor = PP_F_KPA;
            4'h5: unit_factor = PP_F_MPA;
            4'h6: unit_factor = PP_F_INHG;
            4'h7: unit_factor = PP_F_MMHG;
            4'h8: unit_factor = PP_F_MH2O;
            default: unit_factor = user;
        endcase
    endfunction

    // Q16.16 multiply; overflow wraps, a limit of the 32-bit format
    function automatic logic signed [31:0] qmul(
        input logic signed [31:0] a,
        input logic signed [31:0] b
    );
        logic signed [63:0] m;
        m = a * b;
        qmul = m[47:16];
    endfunction

    // Mode word decode; codes outside the table never get stored
    function automatic pp_mode_t decode_mode(input logic [3:0] c);
        pp_mode_t d;
        d.display = 1'b0;
        d.stream = 1'b0;
        d.fan_mark = 1'b0;
        d.sel = PP_SEL_PRESSURE;
        if (c <= PP_MODE_MAX_COMBO) begin
            d.display = c[0];
            d.stream = c[1];
            d.fan_mark = c[2];
        end else if (c == PP_MODE_MASK1) begin
            d.stream = 1'b1;
            d.sel = PP_SEL_MASK1;
        end else if (c == PP_MODE_MASK2) begin
            d.stream = 1'b1;
            d.sel = PP_SEL_MASK2;
        end else if (c == PP_MODE_MASK3) begin
            d.stream = 1'b1;
            d.sel = PP_SEL_MASK3;
        end
        decode_mode = d;
    endfunction

    function automatic logic mode_ok(input logic [3:0] c);
        mode_ok = (c <= PP_MODE_MAX_COMBO) || (c == PP_MODE_MASK1) ||
            (c == PP_MODE_MASK2) || (c == PP_MODE_MASK3);
    endfunction

    // Zero-wait APB slave
    assign setup_ph = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_ff;
    assign PSLVERR = pslverr_ff;

    assign factor = unit_factor(unit_ff, user_factor_ff);
    assign mode = decode_mode(mode_code_ff);
    assign tared = (tare_ff == PP_TARE_ON) ?
        MEAS_PSI - tare_offset_ff : MEAS_PSI;
    assign capture = MEAS_VALID && (tare_ff == PP_TARE_PEND);
    assign tare_wr = wr_en && (PADDR == PP_OFS_TARE_STATE);
    assign tare_set_req = (tare_wr && PWDATA[1:0] == 2'd1) || TARE_REQ_IN;

    // Tare state; lockout guards every change except the pending capture
    always_comb begin
        nxt_tare = tare_ff;
        if (capture) begin
            nxt_tare = PP_TARE_ON;
        end
        if (!lock_ff && tare_set_req) begin
            nxt_tare = PP_TARE_PEND;
        end
        if (!lock_ff && tare_wr && PWDATA[1:0] == 2'd0) begin
            nxt_tare = PP_TARE_OFF;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tare_ff <= PP_TARE_OFF;
        end else begin
            tare_ff <= nxt_tare;
        end
    end

    // Offset: capture beats a software write in the same cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tare_offset_ff <= PP_TARE_OFFSET_RST;
        end else if (capture) begin
            tare_offset_ff <= MEAS_PSI;
        end else if (wr_en && PADDR == PP_OFS_TARE_OFFSET &&
                tare_ff == PP_TARE_ON) begin
            tare_offset_ff <= PWDATA;
        end
    end

    // Any tare start or stop, coefficient change or clear forces reload
    assign reload_set = capture ||
        (tare_ff != PP_TARE_OFF && nxt_tare == PP_TARE_OFF) ||
        COEFF_CHANGED ||
        (wr_en && PADDR == PP_OFS_EXT_CLEAR && PWDATA[0]);

    // Reload starts set so the first measurement seeds both extremes
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            reload_ff <= 1'b1;
        end else begin
            reload_ff <= (reload_ff && !MEAS_VALID) || reload_set;
        end
    end

    // Acknowledge waits for the reload measurement
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_pend_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= MEAS_VALID && ack_pend_ff && reload_ff;
            ack_pend_ff <= (ack_pend_ff && !(MEAS_VALID && reload_ff)) ||
                (wr_en && PADDR == PP_OFS_EXT_CLEAR && PWDATA[0]);
        end
    end

    // Extremes kept in tared psi and scaled on read
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_ff <= '0;
            high_ff <= '0;
        end else if (MEAS_VALID && reload_ff) begin
            low_ff <= '{value: tared, stamp: TIME_STAMP};
            high_ff <= '{value: tared, stamp: TIME_STAMP};
        end else if (MEAS_VALID) begin
            if (tared < low_ff.value) begin
                low_ff <= '{value: tared, stamp: TIME_STAMP};
            end
            if (tared > high_ff.value) begin
                high_ff <= '{value: tared, stamp: TIME_STAMP};
            end
        end
    end

    // Scaled live pressure, latched per measurement
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pressure_ff <= '0;
            pvalid_ff <= 1'b0;
        end else begin
            pvalid_ff <= MEAS_VALID;
            if (MEAS_VALID) begin
                pressure_ff <= qmul(tared, factor);
            end
        end
    end

    // Sensor temperature in the chosen scale
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            temp_ff <= '0;
        end else if (temp_unit_ff) begin
            temp_ff <= qmul(SENSOR_TEMP_C, PP_F_NINE_FIFTHS) +
                PP_F_OFFSET32;
        end else begin
            temp_ff <= SENSOR_TEMP_C;
        end
    end

    // Mode reloads from storage once after reset, writes go back out
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_code_ff <= PP_MODE_RST;
            nv_loaded_ff <= 1'b0;
            nv_stb_ff <= 1'b0;
            nv_data_ff <= PP_MODE_RST;
        end else begin
            nv_stb_ff <= 1'b0;
            nv_loaded_ff <= 1'b1;
            if (!nv_loaded_ff) begin
                if (mode_ok(NV_MODE_IN)) begin
                    mode_code_ff <= NV_MODE_IN;
                end
            end else if (wr_en && PADDR == PP_OFS_OUT_MODE &&
                    mode_ok(PWDATA[3:0])) begin
                mode_code_ff <= PWDATA[3:0];
                nv_stb_ff <= 1'b1;
                nv_data_ff <= PWDATA[3:0];
            end
        end
    end

    // Plain configuration registers; out-of-range codes are dropped
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            unit_ff <= PP_UNIT_RST;
            user_factor_ff <= PP_USER_FACTOR_RST;
            temp_unit_ff <= 1'b0;
            lock_ff <= 1'b0;
            format_ff <= '0;
        end else if (wr_en) begin
            if (PADDR == PP_OFS_UNIT && PWDATA[3:0] <= PP_UNIT_MAX &&
                    PWDATA[31:4] == '0) begin
                unit_ff <= PWDATA[3:0];
            end else if (PADDR == PP_OFS_USER_FACTOR) begin
                user_factor_ff <= PWDATA;
            end else if (PADDR == PP_OFS_TEMP_UNIT &&
                    PWDATA[31:1] == '0) begin
                temp_unit_ff <= PWDATA[0];
            end else if (PADDR == PP_OFS_TARE_LOCK) begin
                lock_ff <= PWDATA[0];
            end else if (PADDR == PP_OFS_FORMAT) begin
                format_ff <= PWDATA[8:0];
            end
        end
    end

    // Read mux; extremes pass through the active unit factor
    always_comb begin
        rdata = '0;
        rdata_err = 1'b0;
        if (PADDR == PP_OFS_OUT_MODE) begin
            rdata[3:0] = mode_code_ff;
        end else if (PADDR == PP_OFS_UNIT) begin
            rdata[3:0] = unit_ff;
        end else if (PADDR == PP_OFS_USER_FACTOR) begin
            rdata = user_factor_ff;
        end else if (PADDR == PP_OFS_TEMP_UNIT) begin
            rdata[0] = temp_unit_ff;
        end else if (PADDR == PP_OFS_TARE_STATE) begin
            rdata[1:0] = tare_ff;
        end else if (PADDR == PP_OFS_TARE_OFFSET) begin
            rdata = tare_offset_ff;
        end else if (PADDR == PP_OFS_TARE_LOCK) begin
            rdata[0] = lock_ff;
        end else if (PADDR == PP_OFS_EXT_CLEAR) begin
            rdata[0] = ack_pend_ff;
        end else if (PADDR == PP_OFS_LOW_VALUE) begin
            rdata = qmul(low_ff.value, factor);
        end else if (PADDR == PP_OFS_LOW_STAMP) begin
            rdata = low_ff.stamp;
        end else if (PADDR == PP_OFS_HIGH_VALUE) begin
            rdata = qmul(high_ff.value, factor);
        end else if (PADDR == PP_OFS_HIGH_STAMP) begin
            rdata = high_ff.stamp;
        end else if (PADDR == PP_OFS_FORMAT) begin
            rdata[8:0] = format_ff;
        end else if (PADDR == PP_OFS_PRESSURE) begin
            rdata = pressure_ff;
        end else if (PADDR == PP_OFS_TEMP) begin
            rdata = temp_ff;
        end else if (PADDR == PP_OFS_STATUS) begin
            rdata[4:0] = {reload_ff, AIR_TEMP_PLUS, STREAM_EN,
                DISPLAY_EN, lock_ff};
        end else begin
            rdata_err = 1'b1;
        end
    end

    // Read data caught in setup so it is a flop by the access phase
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup_ph) begin
            prdata_ff <= PWRITE ? '0 : rdata;
            pslverr_ff <= rdata_err;
        end
    end

    // Output steering and stream suspension
    assign DISPLAY_EN = mode.display;
    assign STREAM_EN = mode.stream && !SINGLE_MEAS_BUSY &&
        !(CONT_MEAS_ACTIVE && mode.sel == PP_SEL_PRESSURE);
    assign STREAM_SEL = mode.sel;
    assign OUT_PORT_SEL = format_ff[PP_FMT_PORT_BIT];
    assign AIR_TEMP_PLUS = mode.fan_mark && FAN_FAULT;
    assign DATE_FMT = format_ff[PP_FMT_DATE_LSB +: 4];
    assign TIME_FMT = format_ff[PP_FMT_TIME_LSB +: 4];
    assign PRESSURE_OUT = pressure_ff;
    assign PRESSURE_VALID = pvalid_ff;
    assign TEMP_OUT = temp_ff;
    assign CLEAR_ACK = ack_ff;
    assign NV_SAVE_STB = nv_stb_ff;
    assign NV_SAVE_DATA = nv_data_ff;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    ext_reload_a: assert property (MEAS_VALID && reload_ff |=>
        low_ff.value == high_ff.value &&
        low_ff.value == $past(tared))
        else $error("extremes not reloaded");
    low_track_a: assert property (MEAS_VALID && !reload_ff &&
        tared < low_ff.value |=> low_ff.value == $past(tared) &&
        low_ff.stamp == $past(TIME_STAMP))
        else $error("minimum not tracked");
    clear_ack_a: assert property (CLEAR_ACK |->
        $past(MEAS_VALID) && $past(ack_pend_ff))
        else $error("ack without reload");
    tare_cap_a: assert property (capture && !tare_wr && !TARE_REQ_IN |=>
        tare_ff == PP_TARE_ON && tare_offset_ff == $past(MEAS_PSI))
        else $error("tare capture failed");
    lock_hold_a: assert property (lock_ff && tare_ff != PP_TARE_PEND |=>
        tare_ff == $past(tare_ff))
        else $error("locked tare changed");
    tare_off_a: assert property (tare_wr && !lock_ff &&
        PWDATA[1:0] == 2'd0 |=> tare_ff == PP_TARE_OFF ##1 reload_ff)
        else $error("tare not off");
    unit_rej_a: assert property (wr_en && PADDR == PP_OFS_UNIT &&
        PWDATA[3:0] > PP_UNIT_MAX |=> unit_ff == $past(unit_ff))
        else $error("bad unit accepted");
    single_hold_a: assert property (SINGLE_MEAS_BUSY |-> !STREAM_EN)
        else $error("stream during single measurement");
    cont_hold_a: assert property (CONT_MEAS_ACTIVE &&
        STREAM_SEL == PP_SEL_PRESSURE |-> !STREAM_EN)
        else $error("pressure stream not held");
    nv_save_a: assert property (nv_loaded_ff && wr_en &&
        PADDR == PP_OFS_OUT_MODE && mode_ok(PWDATA[3:0]) |=>
        NV_SAVE_STB && NV_SAVE_DATA == $past(PWDATA[3:0]) ##1 !NV_SAVE_STB)
        else $error("mode not saved");
    fan_mark_a: assert property (AIR_TEMP_PLUS |->
        FAN_FAULT && mode_code_ff[2] && mode_code_ff <= PP_MODE_MAX_COMBO)
        else $error("fan marker wrong");

    tare_cycle_c: cover property (tare_ff == PP_TARE_PEND ##1
        tare_ff == PP_TARE_ON);
    clear_seen_c: cover property (CLEAR_ACK);
    mask_stream_c: cover property (STREAM_EN &&
        STREAM_SEL == PP_SEL_MASK3);
    lock_pend_c: cover property (lock_ff && capture);

endmodule

// [testbench/pp_meas_src.sv]
// Measurement source model for the sensor side of the block
`timescale 1ns/1ps
module pp_meas_src
    import pp_pkg::*;
(
    input wire logic clk,
    output logic meas_valid,
    output logic signed [31:0] meas_psi,
    output logic [31:0] time_stamp
);
    // Idle value is scrambled so stale data never looks valid
    initial begin
        meas_valid = 1'b0;
        meas_psi = 32'h5A5A_A5A5;
        time_stamp = 32'h0000_0000;
    end

    // One sample, valid for exactly one edge, then the value is inverted
    task automatic measure(input logic signed [31:0] psi,
        input logic [31:0] stamp);
        @(posedge clk);
        meas_valid <= 1'b1;
        meas_psi <= psi;
        time_stamp <= stamp;
        @(posedge clk);
        meas_valid <= 1'b0;
        meas_psi <= ~psi;
    endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the pressure post-processing block
`timescale 1ns/1ps
module testbench
    import pp_pkg::*;
;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, tstamp;
    logic mvalid, coeff, sbusy, cact, fan, nv_stb, pvalid, cack, treq;
    logic signed [31:0] mpsi, p_out, t_out, tc;
    logic [3:0] nv_mode, nv_data, dfmt, tfmt;
    logic disp, strm, psel_out, plus;
    logic [1:0] ssel;
    int fail_count, samples_checked;

    pp_meas_src src (.clk(clk), .meas_valid(mvalid), .meas_psi(mpsi),
        .time_stamp(tstamp));

    // Every input of the block is driven by the bench
    pp_postproc_top DUT (.CLK(clk), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MEAS_VALID(mvalid), .MEAS_PSI(mpsi),
        .TIME_STAMP(tstamp), .SENSOR_TEMP_C(tc),
        .COEFF_CHANGED(coeff), .TARE_REQ_IN(treq),
        .SINGLE_MEAS_BUSY(sbusy), .CONT_MEAS_ACTIVE(cact),
        .FAN_FAULT(fan), .NV_MODE_IN(nv_mode), .NV_SAVE_STB(nv_stb),
        .NV_SAVE_DATA(nv_data), .PRESSURE_OUT(p_out),
        .PRESSURE_VALID(pvalid), .TEMP_OUT(t_out), .CLEAR_ACK(cack),
        .DISPLAY_EN(disp), .STREAM_EN(strm), .STREAM_SEL(ssel),
        .OUT_PORT_SEL(psel_out), .AIR_TEMP_PLUS(plus), .DATE_FMT(dfmt),
        .TIME_FMT(tfmt));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got,
        input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // Setup then access; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            finish_test;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string s, input logic [7:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(s, rd, e);
    endtask

    task automatic meas_chk(input logic [31:0] psi, input logic [31:0] e);
        src.measure(psi, 32'h0000_0000);
        @(negedge clk);
        chk("valid", 32'(pvalid), 32'h0000_0001);
        chk("pressure", p_out, e);
    endtask

    task automatic test_reset;
        rdchk("unit", PP_OFS_UNIT, 32'h0000_0001);
        rdchk("tare state", PP_OFS_TARE_STATE, 32'h0000_0000);
        rdchk("offset", PP_OFS_TARE_OFFSET, 32'h0000_0000);
        rdchk("lock", PP_OFS_TARE_LOCK, 32'h0000_0000);
        rdchk("mode", PP_OFS_OUT_MODE, 32'h0000_0006);
        rdchk("factor", PP_OFS_USER_FACTOR, PP_USER_FACTOR_RST);
        rdchk("temp unit", PP_OFS_TEMP_UNIT, 32'h0000_0000);
        chk("fan mark", 32'(plus), 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'(err), 32'h0000_0001);
    endtask

    task automatic test_modes;
        logic [3:0] c[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
            4'h7, 4'h8, 4'hA, 4'hC};
        logic [3:0] m;
        for (int i = 0; i < 11; i++) begin
            m = c[i];
            wr(PP_OFS_OUT_MODE, 32'(m));
            @(negedge clk);
            chk("save stb", 32'(nv_stb), 32'h0000_0001);
            chk("save data", 32'(nv_data), 32'(m));
            chk("display", 32'(disp), 32'(m[0] & ~m[3]));
            chk("stream", 32'(strm), 32'(m[1] | m[3]));
            chk("plus", 32'(plus), 32'(m[2] & ~m[3]));
            chk("sel", 32'(ssel), m[3] ? 32'(m[2:1]) + 1 : 0);
        end
        // Codes outside the table leave the mode alone
        wr(PP_OFS_OUT_MODE, 32'h0000_0009);
        @(negedge clk);
        chk("save stb", 32'(nv_stb), 32'h0000_0000);
        rdchk("mode", PP_OFS_OUT_MODE, 32'h0000_000C);
        wr(PP_OFS_OUT_MODE, 32'h0000_0003);
        sbusy <= 1'b1;
        @(negedge clk);
        chk("stream", 32'(strm), 32'h0000_0000);
        chk("display", 32'(disp), 32'h0000_0001);
        @(posedge clk);
        sbusy <= 1'b0;
        cact <= 1'b1;
        @(negedge clk);
        chk("stream", 32'(strm), 32'h0000_0000);
        @(posedge clk);
        cact <= 1'b0;
        @(negedge clk);
        chk("stream", 32'(strm), 32'h0000_0001);
        wr(PP_OFS_FORMAT, 32'h0000_0123);
        @(negedge clk);
        chk("port", {psel_out, tfmt, dfmt}, 32'h0000_0123);
    endtask

    task automatic test_extremes;
        wr(PP_OFS_EXT_CLEAR, 32'h0000_0001);
        src.measure(32'h000A_0000, 32'h0000_0011);
        @(negedge clk);
        chk("clear ack", 32'(cack), 32'h0000_0001);
        src.measure(32'h0005_0000, 32'h0000_0022);
        src.measure(32'h0014_0000, 32'h0000_0033);
        src.measure(32'h000C_0000, 32'h0000_0044);
        rdchk("low", PP_OFS_LOW_VALUE, 32'h0005_0000);
        rdchk("low stamp", PP_OFS_LOW_STAMP, 32'h0000_0022);
        rdchk("high", PP_OFS_HIGH_VALUE, 32'h0014_0000);
        rdchk("high stamp", PP_OFS_HIGH_STAMP, 32'h0000_0033);
        @(posedge clk);
        coeff <= 1'b1;
        @(posedge clk);
        coeff <= 1'b0;
        src.measure(32'h000F_0000, 32'h0000_0055);
        rdchk("low", PP_OFS_LOW_VALUE, 32'h000F_0000);
        rdchk("high", PP_OFS_HIGH_VALUE, 32'h000F_0000);
    endtask

    task automatic test_tare;
        wr(PP_OFS_TARE_STATE, 32'h0000_0001);
        rdchk("state", PP_OFS_TARE_STATE, 32'h0000_0001);
        src.measure(32'h0003_0000, 32'h0000_0000);
        rdchk("state", PP_OFS_TARE_STATE, 32'h0000_0002);
        rdchk("offset", PP_OFS_TARE_OFFSET, 32'h0003_0000);
        meas_chk(32'h000A_0000, 32'h0007_0000);
        wr(PP_OFS_TARE_OFFSET, 32'h0001_0000);
        meas_chk(32'h000A_0000, 32'h0009_0000);
        wr(PP_OFS_TARE_STATE, 32'h0000_0001);
        meas_chk(32'h0004_0000, 32'h0004_0000);
        meas_chk(32'h000A_0000, 32'h0006_0000);
        wr(PP_OFS_TARE_LOCK, 32'h0000_0001);
        // A line request under lockout must not touch the state
        @(posedge clk);
        treq <= 1'b1;
        @(posedge clk);
        treq <= 1'b0;
        wr(PP_OFS_TARE_STATE, 32'h0000_0000);
        rdchk("state", PP_OFS_TARE_STATE, 32'h0000_0002);
        wr(PP_OFS_TARE_LOCK, 32'h0000_0000);
        wr(PP_OFS_TARE_STATE, 32'h0000_0000);
        meas_chk(32'h000A_0000, 32'h000A_0000);
        @(posedge clk);
        treq <= 1'b1;
        @(posedge clk);
        treq <= 1'b0;
        wr(PP_OFS_TARE_LOCK, 32'h0000_0001);
        src.measure(32'h0006_0000, 32'h0000_0000);
        rdchk("state", PP_OFS_TARE_STATE, 32'h0000_0002);
        rdchk("offset", PP_OFS_TARE_OFFSET, 32'h0006_0000);
        wr(PP_OFS_TARE_LOCK, 32'h0000_0000);
        wr(PP_OFS_TARE_STATE, 32'h0000_0000);
    endtask

    task automatic test_units;
        logic [31:0] f[8] = '{PP_F_PSI, PP_F_HPA, PP_F_BAR, PP_F_KPA,
            PP_F_MPA, PP_F_INHG, PP_F_MMHG, PP_F_MH2O};
        for (int u = 1; u <= 8; u++) begin
            wr(PP_OFS_UNIT, 32'(u));
            meas_chk(32'h0001_0000, f[u-1]);
        end
        wr(PP_OFS_USER_FACTOR, 32'h0002_0000);
        wr(PP_OFS_UNIT, 32'h0000_0000);
        meas_chk(32'h0001_0000, 32'h0002_0000);
        wr(PP_OFS_UNIT, 32'h0000_0009);
        rdchk("unit", PP_OFS_UNIT, 32'h0000_0000);
        chk("temp c", t_out, 32'h000A_0000);
        wr(PP_OFS_TEMP_UNIT, 32'h0000_0001);
        repeat (3) @(negedge clk);
        chk("temp", t_out, 10 * PP_F_NINE_FIFTHS + PP_F_OFFSET32);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // NV store holds mode 6 so the power-up load is visible
    initial begin
        {resetn, psel, penable, pwrite, coeff, sbusy, cact, treq} = 8'h00;
        tc = 32'h000A_0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fan = 1'b1;
        nv_mode = 4'h6;
        fail_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset;
        test_modes;
        test_extremes;
        test_tare;
        test_units;
        finish_test;
    end
endmodule
